// ===== pfab_pkg.sv
// Purpose: constants, types and register map for the pixel fog / alpha blend block
// Assumes: 32-bit AXI4-Lite register port, one pixel stream in and out
// Notes: table entries sit one per word where address bit TBL_BIT is set
// Functional notes
// RQ1: Fog off passes colour unchanged; fog on blends tint by fog alpha.
// RQ2: Default fog alpha comes from 64-entry table indexed by 1/W MSBs.
// RQ3: Eight low 1/W bits interpolate between adjacent table entries.
// RQ4: Fog bits 1 and 2 zero the tint term and colour term respectively.
// RQ5: Fog bit 3 uses integer iterated alpha as fog alpha.
// RQ6: Fog bit 4 uses top eight Z bits; wins over bit 3.
// RQ7: Fog bit 5 overrides bits 4:3 and adds tint to colour.
// RQ8: Fog bit 6 enables fog dither; bit 7 enables signed fog delta.
// RQ9: Four 2-bit dither rotation selects, used only with rotation enabled.
// RQ10: Alpha test compares source alpha to top-byte reference by 3-bit function.
// RQ11: Function codes: never, lt, eq, le, gt, ne, ge, always.
// RQ12: Failed test counts a reject and writes no buffer at all.
// RQ13: RGB written only when test passes and RGB write enable set.
// RQ14: RGB blend src*alpha with dst*beta; bit 8 order, bit 9 subtract.
// RQ15: Alpha blend likewise with own factors; bit 10 order, bit 11 subtract.
// RQ16: Four 4-bit factor fields: RGB src, RGB dst, alpha src, alpha dst.
// RQ17: Colour factor codes 0x0..0x9 as listed; 0xa..0xe reserved.
// RQ18: Code 0x2 takes the other pixel's colour.
// RQ19: Code 0x8 takes the pixel's own colour.
// RQ20: Code 0xf: dst takes pre-fog colour; src takes min(As, 1-Ad).
// RQ21: 15/16 bpp alpha factors support only zero and one.
// RQ22: 32 bpp alpha factors support 0,1,3,4,5,7 only.
// RQ23: Fog and blend results clamp to 0..255 per component.
package pfab_pkg;
  localparam int AW = 9;
  // Register byte offsets
  localparam logic [AW-1:0] A_FOG  = 9'h000;
  localparam logic [AW-1:0] A_ABC  = 9'h004;
  localparam logic [AW-1:0] A_TINT = 9'h008;
  localparam logic [AW-1:0] A_BWM  = 9'h00c;
  localparam logic [AW-1:0] A_RCFG = 9'h010;
  localparam logic [AW-1:0] A_REJ  = 9'h014;
  localparam int TBL_BIT = 8; // Address bit that selects the table
  // fog_control fields
  localparam int FOG_EN = 0, FOG_NOADD = 1, FOG_NOMUL = 2, FOG_ITA = 3;
  localparam int FOG_Z = 4, FOG_CONST = 5, FOG_DITH = 6, FOG_SDELTA = 7;
  localparam int RGB_ORD = 8, RGB_SUB = 9, ALP_ORD = 10, ALP_SUB = 11;
  localparam int ROT_NORM = 12, ROT_SUB = 14, ROT_AA = 16, ROT_AASUB = 18;
  // alpha_test_blend_control fields
  localparam int AT_EN = 0, AT_FN = 1, BL_EN = 4;
  localparam int F_RS = 8, F_RD = 12, F_AS = 16, F_AD = 20, AREF = 24;
  // buffer_write_mode and render_config fields
  localparam int BWM_RGB_WE = 9, BWM_Z_WE = 10, BWM_AUX_A = 18;
  localparam int RC_ROT = 25;
  localparam logic [1:0] BPP32 = 2'h2;
  // Reset values
  localparam logic [31:0] RST_FOG = 32'h0, RST_ABC = 32'h0, RST_BWM = 32'h0;
  localparam logic [31:0] RST_RCFG = 32'h0, RST_REJ = 32'h0;
  localparam logic [23:0] RST_TINT = 24'h0;
  localparam logic [1:0] RESP_OK = 2'h0, RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    AF_NEVER, AF_LT, AF_EQ, AF_LE, AF_GT, AF_NE, AF_GE, AF_ALWAYS
  } pfab_afunc_e;
  // Blend factor codes
  localparam logic [3:0] FACTOR_ZERO = 4'h0, FACTOR_SOURCE_ALPHA = 4'h1;
  localparam logic [3:0] FACTOR_OTHER_COLOUR = 4'h2, FACTOR_DEST_ALPHA = 4'h3;
  localparam logic [3:0] FACTOR_ONE = 4'h4, FACTOR_INV_SOURCE_ALPHA = 4'h5;
  localparam logic [3:0] FACTOR_INV_OTHER_COLOUR = 4'h6;
  localparam logic [3:0] FACTOR_INV_DEST_ALPHA = 4'h7, FACTOR_OWN_COLOUR = 4'h8;
  localparam logic [3:0] FACTOR_INV_OWN_COLOUR = 4'h9, FACTOR_SPECIAL = 4'hf;
  // Colour words are {a, r, g, b}
  typedef struct packed {
    logic [31:0] colour;   // From the colour combine unit
    logic [31:0] dst;      // Old frame buffer pixel
    logic [7:0]  it_alpha; // Integer part of iterated alpha
    logic [15:0] it_z;     // Clamped iterated Z
    logic [13:0] recip_w;  // Normalised 1/W: [13:8] index, [7:0] fraction
    logic        aa_rep;   // Triangle repeated for antialiasing
  } pfab_pin_s;
  typedef struct packed {
    logic [31:0] colour;
    logic        we_a, we_rgb, we_z, we_stencil;
    logic        rot_en;
    logic [1:0]  rot_sel, rot_sub_sel;
    logic        fog_dith;
  } pfab_pout_s;
endpackage : pfab_pkg

// ===== pfab_core.sv
// Purpose: fog stage, alpha test and frame buffer blend for one pixel stream
// Assumes: AXI4-Lite master issues one write and one read at a time
// Notes: result is registered; the stream accepts at most every other cycle
`timescale 1ns/10ps
`default_nettype none
module pfab_core
  import pfab_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire pfab_pin_s     pix_in,
  input  wire logic          in_valid,
  output logic               in_ready,
  output pfab_pout_s         pix_out,
  output logic               out_valid,
  input  wire logic          out_ready
);

  typedef struct packed {
    logic [31:0]      fog, abc, bwm, rcfg, rej;
    logic [23:0]      tint;
    logic [63:0][7:0] tbl;
    logic             aw_have, w_have;
    logic [AW-1:0]    waddr;
    logic [31:0]      wd;
    logic [3:0]       ws;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata;
    logic             in_ready, out_valid;
    pfab_pout_s       pout;
  } pfab_st_s;

  pfab_st_s st_r, st_nxt;

  // Scale x by f/255, approximated as x*(f+1)/256 so that f=255 is exact
  function automatic logic [7:0] mul8(input logic [7:0] x, input logic [7:0] f);
    logic [16:0] p;
    p = 17'(x) * (17'(f) + 17'h1);
    return p[15:8];
  endfunction : mul8

  // Unsigned 9-bit sum clamped to a component
  function automatic logic [7:0] sat9(input logic [8:0] v);
    return v[8] ? 8'hff : v[7:0];
  endfunction : sat9

  // Signed blend result clamped to a component
  function automatic logic [7:0] clamp(input logic signed [9:0] v);
    logic [7:0] r;
    r = v[7:0];
    if (v < 10'sd0) r = 8'h00;
    else if (v > 10'sd255) r = 8'hff;
    return r;
  endfunction : clamp

  // Colour channel factor; dside marks use as the destination factor
  function automatic logic [7:0] cfac(input logic [3:0] code, input logic dside,
      input logic [7:0] sc, input logic [7:0] dc, input logic [7:0] sa,
      input logic [7:0] da, input logic [7:0] pre);
    logic [7:0] f;
    f = 8'h00;
    case (code)
      FACTOR_ZERO:             f = 8'h00;
      FACTOR_SOURCE_ALPHA:     f = sa;
      FACTOR_OTHER_COLOUR:     f = dside ? sc : dc;       // RQ18
      FACTOR_DEST_ALPHA:       f = da;
      FACTOR_ONE:              f = 8'hff;
      FACTOR_INV_SOURCE_ALPHA: f = ~sa;
      FACTOR_INV_OTHER_COLOUR: f = dside ? ~sc : ~dc;     // RQ18
      FACTOR_INV_DEST_ALPHA:   f = ~da;
      FACTOR_OWN_COLOUR:       f = dside ? dc : sc;       // RQ19
      FACTOR_INV_OWN_COLOUR:   f = dside ? ~dc : ~sc;     // RQ19
      FACTOR_SPECIAL: begin                               // RQ20
        if (dside) f = pre;
        else f = (sa < ~da) ? sa : ~da;
      end
      default:                 f = 8'h00;                 // RQ17
    endcase
    return f;
  endfunction : cfac

  // Alpha channel factor; reserved codes act as zero
  function automatic logic [7:0] afac(input logic [3:0] code, input logic b32,
      input logic [7:0] sa, input logic [7:0] da);
    logic [7:0] f;
    f = 8'h00;
    if (!b32) begin
      if (code == FACTOR_ONE) f = 8'hff;                  // RQ21
    end else begin
      case (code)                                         // RQ22
        FACTOR_SOURCE_ALPHA:     f = sa;
        FACTOR_DEST_ALPHA:       f = da;
        FACTOR_ONE:              f = 8'hff;
        FACTOR_INV_SOURCE_ALPHA: f = ~sa;
        FACTOR_INV_DEST_ALPHA:   f = ~da;
        default:                 f = 8'h00;
      endcase
    end
    return f;
  endfunction : afac

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Pixel datapath temporaries
  logic [5:0]        idx, idx1;
  logic [7:0]        fr, e0, e1, tbl_a, fog_a, cin, ct, sa, da, fs, fd, ts, td;
  logic signed [8:0] dlt;
  logic signed [17:0] dprod;
  logic [8:0]        sum9;
  logic signed [9:0] bl;
  logic [31:0]       fogged;
  logic [31:0]       blended;
  logic [7:0]        aref;
  logic              pass, accept, b32, rej_clr, rej_inc, ord, sub;
  logic [31:0]       rd;
  logic              rd_ok;
  pfab_afunc_e       afn;

  // Next-state logic for the bus slave and the pixel stage
  always_comb begin
    st_nxt = st_r;
    accept = in_valid & st_r.in_ready;
    rej_clr = 1'b0;
    // Write channel: address and data land in either order
    if (awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.waddr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wd = wdata;
      st_nxt.ws = wstrb;
    end
    if (bvalid && bready) st_nxt.bvalid = 1'b0;
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OK;
      if (st_r.waddr[TBL_BIT]) begin
        if (st_r.ws[0]) st_nxt.tbl[st_r.waddr[7:2]] = st_r.wd[7:0]; // RQ2
      end else begin
        case ({st_r.waddr[AW-1:2], 2'b00})
          A_FOG:  st_nxt.fog = merge(st_r.fog, st_r.wd, st_r.ws);
          A_ABC:  st_nxt.abc = merge(st_r.abc, st_r.wd, st_r.ws);
          A_TINT: st_nxt.tint = 24'(merge({8'h00, st_r.tint}, st_r.wd, st_r.ws));
          A_BWM:  st_nxt.bwm = merge(st_r.bwm, st_r.wd, st_r.ws);
          A_RCFG: st_nxt.rcfg = merge(st_r.rcfg, st_r.wd, st_r.ws);
          A_REJ:  rej_clr = 1'b1;
          default: st_nxt.bresp = RESP_ERR;
        endcase
      end
    end
    st_nxt.awready = ~st_nxt.aw_have & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_have & ~st_nxt.bvalid;

    // Read channel: one outstanding read, unmapped answers with an error
    rd = 32'h0;
    rd_ok = 1'b1;
    if (araddr[TBL_BIT]) begin
      rd = {24'h0, st_r.tbl[araddr[7:2]]};
    end else begin
      case ({araddr[AW-1:2], 2'b00})
        A_FOG:  rd = st_r.fog;
        A_ABC:  rd = st_r.abc;
        A_TINT: rd = {8'h00, st_r.tint};
        A_BWM:  rd = st_r.bwm;
        A_RCFG: rd = st_r.rcfg;
        A_REJ:  rd = st_r.rej;
        default: rd_ok = 1'b0;
      endcase
    end
    if (rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.arready = 1'b0;
      st_nxt.rdata = rd;
      st_nxt.rresp = rd_ok ? RESP_OK : RESP_ERR;
    end

    // Fog alpha from the table with interpolation on the 1/W fraction
    idx = pix_in.recip_w[13:8];                                  // RQ2
    fr = pix_in.recip_w[7:0];                                    // RQ3
    idx1 = (idx == 6'h3f) ? idx : idx + 6'h1;
    e0 = st_r.tbl[idx];
    e1 = st_r.tbl[idx1];
    dlt = $signed({1'b0, e1}) - $signed({1'b0, e0});
    // Unsigned delta mode cannot step down, so a falling curve holds
    if (!st_r.fog[FOG_SDELTA] && dlt < 9'sd0) dlt = 9'sd0;       // RQ8
    dprod = 18'(dlt) * $signed({10'h0, fr});                     // RQ3
    tbl_a = 8'(e0 + 8'(dprod >>> 8));
    fog_a = tbl_a;
    if (st_r.fog[FOG_Z]) fog_a = pix_in.it_z[15:8];              // RQ6
    else if (st_r.fog[FOG_ITA]) fog_a = pix_in.it_alpha;         // RQ5

    // Fog per colour channel; alpha passes through
    fogged = pix_in.colour;                                      // RQ1
    for (int c = 0; c < 3; c++) begin
      cin = pix_in.colour[8*c +: 8];
      ct = st_r.tint[8*c +: 8];
      sum9 = {1'b0, cin};
      if (st_r.fog[FOG_EN]) begin
        if (st_r.fog[FOG_CONST]) begin
          sum9 = {1'b0, cin} + {1'b0, ct};                       // RQ7
        end else begin
          sum9 = 9'h0;                                           // RQ4
          if (!st_r.fog[FOG_NOADD]) sum9 = {1'b0, mul8(ct, fog_a)};
          if (!st_r.fog[FOG_NOMUL]) sum9 = sum9 + {1'b0, mul8(cin, ~fog_a)};
        end
      end
      fogged[8*c +: 8] = sat9(sum9);                             // RQ23
    end

    // Alpha test against the reference byte
    sa = pix_in.colour[31:24];
    da = pix_in.dst[31:24];
    aref = st_r.abc[AREF +: 8];                                  // RQ10
    afn = pfab_afunc_e'(st_r.abc[AT_FN +: 3]);
    case (afn)                                                   // RQ11
      AF_NEVER:  pass = 1'b0;
      AF_LT:     pass = sa < aref;
      AF_EQ:     pass = sa == aref;
      AF_LE:     pass = sa <= aref;
      AF_GT:     pass = sa > aref;
      AF_NE:     pass = sa != aref;
      AF_GE:     pass = sa >= aref;
      default:   pass = 1'b1;
    endcase
    if (!st_r.abc[AT_EN]) pass = 1'b1;
    rej_inc = accept & ~pass;                                    // RQ12

    // Blend: channels 0..2 colour, channel 3 alpha
    b32 = st_r.rcfg[1:0] == BPP32;
    blended = fogged;
    for (int c = 0; c < 4; c++) begin
      if (c == 3) begin
        fs = afac(st_r.abc[F_AS +: 4], b32, sa, da);             // RQ16
        fd = afac(st_r.abc[F_AD +: 4], b32, sa, da);
        ord = st_r.fog[ALP_ORD];                                 // RQ15
        sub = st_r.fog[ALP_SUB];
      end else begin
        fs = cfac(st_r.abc[F_RS +: 4], 1'b0, fogged[8*c +: 8], pix_in.dst[8*c +: 8],
                  sa, da, pix_in.colour[8*c +: 8]);              // RQ16
        fd = cfac(st_r.abc[F_RD +: 4], 1'b1, fogged[8*c +: 8], pix_in.dst[8*c +: 8],
                  sa, da, pix_in.colour[8*c +: 8]);
        ord = st_r.fog[RGB_ORD];                                 // RQ14
        sub = st_r.fog[RGB_SUB];
      end
      ts = mul8(fogged[8*c +: 8], fs);
      td = mul8(pix_in.dst[8*c +: 8], fd);
      if (!sub) bl = $signed({2'b00, ts}) + $signed({2'b00, td});
      else if (!ord) bl = $signed({2'b00, ts}) - $signed({2'b00, td});
      else bl = $signed({2'b00, td}) - $signed({2'b00, ts});
      if (st_r.abc[BL_EN]) blended[8*c +: 8] = clamp(bl);        // RQ23
    end

    // Reject counter: a miss in the clearing cycle still counts
    st_nxt.rej = (rej_clr ? 32'h0 : st_r.rej) + {31'h0, rej_inc}; // RQ12

    // Output register with a single-entry hand-off
    if (out_valid && out_ready) st_nxt.out_valid = 1'b0;
    if (accept) begin
      st_nxt.out_valid = 1'b1;
      st_nxt.pout.colour = blended;
      st_nxt.pout.we_rgb = pass & st_r.bwm[BWM_RGB_WE];          // RQ13
      st_nxt.pout.we_a = pass & st_r.bwm[BWM_AUX_A];             // RQ12
      st_nxt.pout.we_z = pass & st_r.bwm[BWM_Z_WE];
      st_nxt.pout.we_stencil = pass;
      st_nxt.pout.rot_en = st_r.rcfg[RC_ROT];                    // RQ9
      st_nxt.pout.rot_sel = 2'h0;
      st_nxt.pout.rot_sub_sel = 2'h0;
      if (st_r.rcfg[RC_ROT]) begin
        st_nxt.pout.rot_sel = pix_in.aa_rep ? st_r.fog[ROT_AA +: 2]
                                            : st_r.fog[ROT_NORM +: 2];
        st_nxt.pout.rot_sub_sel = pix_in.aa_rep ? st_r.fog[ROT_AASUB +: 2]
                                                : st_r.fog[ROT_SUB +: 2];
      end
      st_nxt.pout.fog_dith = st_r.fog[FOG_EN] & st_r.fog[FOG_DITH]; // RQ8
    end
    // Trade-off: ready is registered, so full rate is halved
    st_nxt.in_ready = ~st_nxt.out_valid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.fog <= RST_FOG;
      st_r.abc <= RST_ABC;
      st_r.bwm <= RST_BWM;
      st_r.rcfg <= RST_RCFG;
      st_r.rej <= RST_REJ;
      st_r.tint <= RST_TINT;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.in_ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign in_ready = st_r.in_ready;
  assign out_valid = st_r.out_valid;
  assign pix_out = st_r.pout;

endmodule : pfab_core
`default_nettype wire

// ===== pfab_core_asserts.sv
// Purpose: concurrent checks on the pixel stream and register port of pfab_core
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench; sees only top-level ports
`timescale 1ns/10ps
`default_nettype none
module pfab_core_asserts
  import pfab_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic       in_valid,
  input wire logic       in_ready,
  input wire pfab_pout_s pix_out,
  input wire logic       out_valid,
  input wire logic       out_ready
);
  // Reset masks every check, so values held during reset never count
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Stream steps: accept, held by back pressure, handed over
  sequence s_px_taken;
    in_valid && in_ready;
  endsequence
  sequence s_px_held;
    out_valid && !out_ready;
  endsequence
  sequence s_px_given;
    out_valid && out_ready;
  endsequence

  a_px_answer: assert property (s_px_taken |=> out_valid)
    else $error("no result one cycle after accept");
  a_px_stands: assert property (s_px_held |=> out_valid && $stable(pix_out))
    else $error("result changed while held");
  a_px_block: assert property (out_valid |-> !in_ready)
    else $error("input open while result pending");
  a_px_drop: assert property (s_px_given |=> !out_valid && in_ready)
    else $error("stream did not reopen after handover");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_rd_stands: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read data changed while held");
  a_wr_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed while held");
  a_reject_nowrite: assert property (out_valid && !pix_out.we_stencil |->
    !(pix_out.we_a || pix_out.we_rgb || pix_out.we_z))
    else $error("rejected pixel still writes");
  a_rot_gate: assert property (out_valid && !pix_out.rot_en |->
    pix_out.rot_sel == 2'h0 && pix_out.rot_sub_sel == 2'h0)
    else $error("rotation select leaks while disabled");
endmodule : pfab_core_asserts
`default_nettype wire

// ===== pfab_partner.sv
// Purpose: colour combine source and frame buffer sink around pfab_core
// Assumes: bench pulses go for one cycle per pixel
// Notes: slow toggles out_ready so results are held back
`timescale 1ns/10ps
`default_nettype none
module pfab_partner
  import pfab_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire pfab_pin_s  px,
  output pfab_pin_s       pix_in,
  output logic            in_valid,
  input  wire logic       in_ready,
  input  wire pfab_pout_s pix_out,
  input  wire logic       out_valid,
  output logic            out_ready,
  output pfab_pout_s      got,
  output logic            done
);
  // Released bus shows the inverse so a stale pixel is never mistaken for a fresh one
  always_ff @(posedge aclk) begin
    done <= out_valid && out_ready;
    out_ready <= slow ? ~out_ready : 1'b1;
    if (out_valid && out_ready) begin
      got <= pix_out;
    end
    if (!aresetn) begin
      in_valid <= 1'b0;
      out_ready <= 1'b1;
      pix_in <= '0;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      pix_in <= ~pix_in;
    end else if (go) begin
      in_valid <= 1'b1;
      pix_in <= px;
    end
  end
endmodule : pfab_partner
`default_nettype wire

// ===== pixel_fog_alpha_blend_bench.sv
// Purpose: self-checking bench for pfab_core
// Assumes: 25 MHz clock, AXI4-Lite master one transfer at a time
// Notes: expected colours use the x*(f+1)>>8 product
`timescale 1ns/10ps
`default_nettype none
module pixel_fog_alpha_blend_bench;
  import pfab_pkg::*;
  logic            aclk = 1'b0, aresetn = 1'b0;
  logic [AW-1:0]   awaddr = '0, araddr = '0;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic            arvalid = 1'b0, rready = 1'b0, go = 1'b0, slow = 1'b0;
  logic [7:0]      frac = 8'h00;
  logic            aa = 1'b0;
  logic [31:0]     wdata = '0, rdata;
  logic [3:0]      wstrb = 4'hf;
  logic            awready, wready, bvalid, arready, rvalid, done;
  logic            in_valid, in_ready, out_valid, out_ready;
  logic [1:0]      bresp, rresp;
  pfab_pin_s       pix_in, px = '0;
  pfab_pout_s      pix_out, got;
  int              err_total = 0, comparisons = 0;
  // Fog cases: {fog_control, it_alpha, z high byte, colour}
  localparam logic [55:0] FOGC [8] = '{56'h000000_40602030, 56'h1100ff_40c08040,
    56'h1900ff_40c08040, 56'h090000_40602030, 56'h0d0000_40000000,
    56'h1300ff_40000000, 56'h310000_40ffa070, 56'h010000_40c08040};
  // Blend cases: {fog_control, factors ad as rd rs, colour}
  localparam logic [63:0] BLC [16] = '{64'h0000_4444_b0b0b0b0,
    64'h0200_4444_b0505050, 64'h0300_4444_b0000000, 64'h0800_4444_50b0b0b0,
    64'h0c00_4444_00b0b0b0, 64'h0000_0404_80808080, 64'h0000_4040_30303030,
    64'h0000_0408_80404040, 64'h0000_0402_80181818, 64'h0000_044a_80303030,
    64'h0000_040f_80404040, 64'h0021_04f0_80181818, 64'h0000_7171_67676767,
    64'h0000_3535_49494949, 64'h0000_0496_808f8f8f, 64'h0000_0000_00000000};

  always #20 aclk = ~aclk;

  pfab_core i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pix_in, .in_valid, .in_ready, .pix_out, .out_valid,
    .out_ready);
  pfab_partner i_far (.aclk, .aresetn, .go, .slow, .px, .pix_in, .in_valid, .in_ready,
    .pix_out, .out_valid, .out_ready, .got, .done);

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task give_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Address and data go out together; each drops at its own handshake
  task wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    while (1) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (1) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd

  task wok(input logic [AW-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'(RESP_OK), 32'(r));
  endtask : wok

  // One pixel through the partner; returns once the result is captured
  task push(input logic [31:0] c, d, input logic [7:0] ia, zh);
    @(posedge aclk);
    px <= '{c, d, ia, {zh, 8'h00}, {6'd5, frac}, aa};
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    while (!done) @(posedge aclk);
  endtask : push

  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      rd(AW'(4 * i), d, r);
      chk("reset value", 32'h0, d);
    end
    wok(A_FOG, 32'h000a5a5a);
    rd(A_FOG, d, r);
    chk("fog_control rw", 32'h000a5a5a, d);
    wr(9'h020, 32'h1, r);
    chk("unmapped bresp", 32'(RESP_ERR), 32'(r));
    rd(9'h020, d, r);
    chk("unmapped rresp", 32'(RESP_ERR), 32'(r));
  endtask : t_regs

  task t_fog;
    wok(A_TINT, 32'h00c08040);
    wok(9'h114, 32'hff);
    foreach (FOGC[i]) begin
      wok(A_FOG, 32'(FOGC[i][55:48]));
      push(32'h40602030, 32'h0, FOGC[i][47:40], FOGC[i][39:32]);
      chk("fog colour", FOGC[i][31:0], got.colour);
    end
    // Halfway between entry 5 (0xff) and entry 6 (0x00): only a signed delta steps down
    frac <= 8'h80;
    wok(A_FOG, 32'h81);
    push(32'h40602030, 32'h0, 8'h0, 8'h0);
    chk("fog interp", 32'h40905038, got.colour);
    wok(A_FOG, 32'h01);
    push(32'h40602030, 32'h0, 8'h0, 8'h0);
    chk("fog unsigned delta", 32'h40c08040, got.colour);
    frac <= 8'h00;
    wok(A_FOG, 32'h41);
    push(32'h40602030, 32'h0, 8'h0, 8'h0);
    chk("fog dither", 32'h1, 32'(got.fog_dith));
  endtask : t_fog

  // Source alpha at and below the reference only; lt/ne, gt/never, eq/ge and le/always are not told apart
  task t_atest;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] mask;
    logic p;
    wok(A_FOG, 32'h0);
    wok(A_BWM, 32'h200);
    slow <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      mask = k[3] ? 8'haa : 8'hcc;
      p = mask[k % 8];
      wok(A_ABC, {8'h80, 20'h0, 3'(k), 1'b1});
      push(k[3] ? 32'h7f102030 : 32'h80102030, 32'h0, 8'h0, 8'h0);
      chk("we_rgb", 32'(p), 32'(got.we_rgb));
      chk("we_stencil", 32'(p), 32'(got.we_stencil));
    end
    rd(A_REJ, d, r);
    chk("reject count", 32'h8, d);
    wok(A_BWM, 32'h40400);
    push(32'h80102030, 32'h0, 8'h0, 8'h0);
    chk("we_rgb masked", 32'h0, 32'(got.we_rgb));
    chk("we_a we_z", 32'h3, 32'({got.we_a, got.we_z}));
    wok(A_ABC, 32'h80000001);
    push(32'h80102030, 32'h0, 8'h0, 8'h0);
    chk("rejected we_a we_z", 32'h0, 32'({got.we_a, got.we_z}));
    slow <= 1'b0;
  endtask : t_atest

  task t_blend;
    wok(A_RCFG, 32'(BPP32));
    wok(A_BWM, 32'h200);
    foreach (BLC[i]) begin
      wok(A_FOG, 32'(BLC[i][63:48]));
      wok(A_ABC, {8'h0, BLC[i][47:32], 8'h10});
      push(32'h80808080, 32'h30303030, 8'h0, 8'h0);
      chk("blend", BLC[i][31:0], got.colour);
    end
    // 16 bpp drops alpha factors 1 and 7; rotation selects follow aa_rep
    wok(A_RCFG, 32'h02000000);
    wok(A_FOG, 32'h39000);
    wok(A_ABC, 32'h00717110);
    push(32'h80808080, 32'h30303030, 8'h0, 8'h0);
    chk("16bpp blend", 32'h00676767, got.colour);
    chk("rotation", 32'h16, 32'({got.rot_en, got.rot_sel, got.rot_sub_sel}));
    aa <= 1'b1;
    push(32'h80808080, 32'h30303030, 8'h0, 8'h0);
    chk("rotation aa", 32'h1c, 32'({got.rot_en, got.rot_sel, got.rot_sub_sel}));
    aa <= 1'b0;
  endtask : t_blend

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_fog;
    t_atest;
    t_blend;
    give_verdict;
  end

  // Whole run needs well under a thousand cycles; 50000 marks a hang
  initial begin
    #2000000;
    err_total++;
    give_verdict;
  end
endmodule : pixel_fog_alpha_blend_bench

bind pfab_core pfab_core_asserts i_chk (.aclk, .aresetn, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .in_valid, .in_ready, .pix_out,
  .out_valid, .out_ready);
`default_nettype wire
